// ### hdl/bcf_pkg.sv
// Constants and carrier types for the bridge control field block
package bcf_pkg;
  // Register byte offsets on APB
  localparam logic [11:0] OFF_IO_UPPER = 12'h030;
  localparam logic [11:0] OFF_BCTL     = 12'h03c;
  localparam logic [11:0] OFF_IO_LOWER = 12'h080;
  localparam logic [11:0] OFF_ISTAT    = 12'h084;
  localparam logic [11:0] OFF_IMASK    = 12'h088;
  localparam logic [1:0]  WORD_ALIGN   = 2'h0;

  // Bridge control bit positions within the dword at 3Ch
  localparam int BIT_POISON_EN = 16;
  localparam int BIT_ERR_FWD   = 17;
  localparam int BIT_ALIAS_EN  = 18;
  localparam int BIT_VGA_EN    = 19;
  localparam int BIT_VGA16     = 20;
  localparam int BIT_HOT_RST   = 22;

  // Writable bits: 16..20 and 22; 21, 23..31 and low half read zero
  localparam logic [31:0] BCTL_WMASK = 32'h005f0000;
  localparam logic [31:0] BCTL_RESET = 32'h00000000;
  localparam logic [15:0] EXT_RESET  = 16'h0000;

  // VGA windows
  localparam logic [31:0] VGA_MEM_LO = 32'h000a0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000bffff;
  localparam logic [9:0]  VGA_IO_ALO = 10'h3b0;
  localparam logic [9:0]  VGA_IO_AHI = 10'h3bb;
  localparam logic [9:0]  VGA_IO_BLO = 10'h3c0;
  localparam logic [9:0]  VGA_IO_BHI = 10'h3df;

  // Interrupt event bits
  localparam int EV_POISON = 0;
  localparam int EV_ERRFWD = 1;
  localparam int EV_HOTRST = 2;
  localparam int EV_W      = 3;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;

  // Transaction presented to the decoder
  typedef struct packed {
    logic        valid;
    logic        isIo;
    logic        isMem;
    logic        isErrMsg;
    logic        poisoned;
    logic [31:0] addr;
  } bcf_req_t;

  // Registered routing decision
  typedef struct packed {
    logic valid;
    logic fwdDown;
    logic fwdUp;
    logic vgaHit;
    logic errFwd;
    logic poisonRpt;
  } bcf_dec_t;

  typedef enum logic [1:0] {APB_IDLE, APB_SETUP, APB_ACCESS} bcf_apb_t;
endpackage

// ### hdl/bcf_bridge_control.sv
// Bridge control fields, I/O window extension and routing decode
// What this block does
// - Bit 16 clear ignores secondary poisoned TLPs; set detects, reports.
// - Bit 17 enables forwarding secondary error messages to primary.
// - Alias bit 18 clear forwards every I/O window address downstream.
// - Alias set sends low 64KB top-768-byte-per-1KB window addresses up.
// - VGA bit 19 forwards memory 000A0000h to 000BFFFFh, else ignored.
// - VGA bit also forwards low-64KB I/O at 3B0-3BBh and 3C0-3DFh.
// - Bit 20 selects 10-bit or 16-bit VGA I/O decode, reset zero.
// - Downstream port bit 22 issues hot reset to its attached device.
// - Upstream port bit 22 drives hot reset on all downstream ports.
// - Bits 21 and 23 to 27 read zero; writes ignored.
// - I/O base and limit upper 16 bits are writable, reset zero.
`timescale 1ns/1ps
module bcf_bridge_control
(
  input  wire logic             clk_sys,        // Core clock, 100 MHz
  input  wire logic             rst_b,          // Async reset, low
  input  wire logic             portIsUpstream, // Port role strap
  input  wire logic             psel,           // APB select
  input  wire logic             penable,        // APB enable
  input  wire logic             pwrite,         // APB direction
  input  wire logic [11:0]      paddr,          // APB byte address
  input  wire logic [31:0]      pwdata,         // APB write data
  input  wire bcf_pkg::bcf_req_t req,           // Transaction to route
  output logic                  pready,         // APB ready
  output logic                  pslverr,        // APB error
  output logic [31:0]           prdata,         // APB read data
  output bcf_pkg::bcf_dec_t     dec,            // Routing decision
  output logic                  linkHotReset,   // Hot reset own link
  output logic                  allDownHotReset,// Hot reset all downs
  output logic                  irq             // Level interrupt
);

  logic                     rstSync1;
  logic                     rstSync2;
  logic [31:0]              bctl;
  logic [15:0]              ioBaseUp;
  logic [15:0]              ioLimitUp;
  logic [15:0]              ioBaseLo;
  logic [15:0]              ioLimitLo;
  logic [bcf_pkg::EV_W-1:0] istat;
  logic [bcf_pkg::EV_W-1:0] imask;
  logic [bcf_pkg::EV_W-1:0] evSet;
  logic                     hotRstPrev;
  logic                     setupPh;
  logic                     wrDone;
  logic                     mapped;
  logic [31:0]              rdMux;
  logic [31:0]              ioBottom;
  logic [31:0]              ioTop;
  logic                     inIoWin;
  logic                     aliasHit;
  logic                     vgaIo;
  logic                     vgaMem;
  bcf_pkg::bcf_dec_t        next_dec;

  // Does a word address match a given register offset
  function automatic logic hitOff(input logic [11:0] a,
                                  input logic [11:0] off);
    hitOff = (a[11:2] == off[11:2]);
  endfunction

  // Inclusive range test used by the I/O window and VGA memory compares
  function automatic logic inRange(input logic [31:0] a,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // Low ten bits inside either VGA I/O span
  function automatic logic vgaIoLow(input logic [9:0] a);
    vgaIoLow = ((a >= bcf_pkg::VGA_IO_ALO) && (a <= bcf_pkg::VGA_IO_AHI))
            || ((a >= bcf_pkg::VGA_IO_BLO) && (a <= bcf_pkg::VGA_IO_BHI));
  endfunction

  // Reset release through two flops; only constants load on assert
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // APB phase tracking: no wait state, yet read data leaves a flop
  assign setupPh = psel && !penable;
  assign wrDone  = psel && penable && pready && pwrite && !pslverr;
  assign mapped  = (paddr[1:0] == bcf_pkg::WORD_ALIGN)
                && (hitOff(paddr, bcf_pkg::OFF_IO_UPPER)
                 || hitOff(paddr, bcf_pkg::OFF_BCTL)
                 || hitOff(paddr, bcf_pkg::OFF_IO_LOWER)
                 || hitOff(paddr, bcf_pkg::OFF_ISTAT)
                 || hitOff(paddr, bcf_pkg::OFF_IMASK));

  // Read mux; unwritable bridge control bits are never stored
  always_comb
  begin
    rdMux = 32'h00000000;
    if (hitOff(paddr, bcf_pkg::OFF_IO_UPPER))
      rdMux = {ioLimitUp, ioBaseUp};
    else if (hitOff(paddr, bcf_pkg::OFF_BCTL))
      rdMux = bctl & bcf_pkg::BCTL_WMASK;
    else if (hitOff(paddr, bcf_pkg::OFF_IO_LOWER))
      rdMux = {ioLimitLo, ioBaseLo};
    else if (hitOff(paddr, bcf_pkg::OFF_ISTAT))
      rdMux = {29'h0, istat};
    else if (hitOff(paddr, bcf_pkg::OFF_IMASK))
      rdMux = {29'h0, imask};
  end

  // APB answer flops, latched in the setup cycle
  always_ff @(posedge clk_sys or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setupPh;
      pslverr <= setupPh && !mapped;
      if (setupPh)
        prdata <= (mapped && !pwrite) ? rdMux : 32'h00000000;
    end
  end

  // Bridge control: masked write keeps fixed-zero fields at zero
  always_ff @(posedge clk_sys or negedge rstSync2)
  begin
    if (!rstSync2)
      bctl <= bcf_pkg::BCTL_RESET;
    else if (wrDone && hitOff(paddr, bcf_pkg::OFF_BCTL))
      bctl <= pwdata & bcf_pkg::BCTL_WMASK;
  end

  // I/O window extension and low window registers
  always_ff @(posedge clk_sys or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      ioBaseUp  <= bcf_pkg::EXT_RESET;
      ioLimitUp <= bcf_pkg::EXT_RESET;
      ioBaseLo  <= bcf_pkg::EXT_RESET;
      ioLimitLo <= bcf_pkg::EXT_RESET;
    end
    else if (wrDone)
    begin
      if (hitOff(paddr, bcf_pkg::OFF_IO_UPPER))
      begin
        ioBaseUp  <= pwdata[15:0];
        ioLimitUp <= pwdata[31:16];
      end
      if (hitOff(paddr, bcf_pkg::OFF_IO_LOWER))
      begin
        ioBaseLo  <= pwdata[15:0];
        ioLimitLo <= pwdata[31:16];
      end
    end
  end

  // Window and VGA matching on the presented address
  assign ioBottom = {ioBaseUp, ioBaseLo};
  assign ioTop    = {ioLimitUp, ioLimitLo};
  assign inIoWin  = inRange(req.addr, ioBottom, ioTop);
  // Alias space: below 64KB and offset 100h..3FFh within each 1KB
  assign aliasHit = (req.addr[31:16] == 16'h0000)
                 && (req.addr[9:8] != 2'h0);
  // 10-bit decode ignores A15..A10, so aliases above 1KB also match
  assign vgaIo    = (req.addr[31:16] == 16'h0000)
                 && vgaIoLow(req.addr[9:0])
                 && (!bctl[bcf_pkg::BIT_VGA16]
                  || (req.addr[15:10] == 6'h00));
  assign vgaMem   = inRange(req.addr, bcf_pkg::VGA_MEM_LO,
                            bcf_pkg::VGA_MEM_HI);

  // Routing decision; VGA wins over the alias steering for I/O
  always_comb
  begin
    next_dec           = '0;
    next_dec.valid     = req.valid;
    if (req.valid && req.isIo)
    begin
      if (bctl[bcf_pkg::BIT_VGA_EN] && vgaIo)
      begin
        next_dec.vgaHit  = 1'b1;
        next_dec.fwdDown = 1'b1;
      end
      else if (inIoWin)
      begin
        if (bctl[bcf_pkg::BIT_ALIAS_EN] && aliasHit)
          next_dec.fwdUp   = 1'b1;
        else
          next_dec.fwdDown = 1'b1;
      end
    end
    if (req.valid && req.isMem && bctl[bcf_pkg::BIT_VGA_EN] && vgaMem)
    begin
      next_dec.vgaHit  = 1'b1;
      next_dec.fwdDown = 1'b1;
    end
    next_dec.errFwd    = req.valid && req.isErrMsg
                      && bctl[bcf_pkg::BIT_ERR_FWD];
    next_dec.poisonRpt = req.valid && req.poisoned
                      && bctl[bcf_pkg::BIT_POISON_EN];
  end

  // Decision leaves a flop one cycle after the request
  always_ff @(posedge clk_sys or negedge rstSync2)
  begin
    if (!rstSync2)
      dec <= '0;
    else
      dec <= next_dec;
  end

  // Hot reset levels follow bit 22 for as long as it stays set
  always_ff @(posedge clk_sys or negedge rstSync2)
  begin
    if (!rstSync2)
    begin
      linkHotReset    <= 1'b0;
      allDownHotReset <= 1'b0;
      hotRstPrev      <= 1'b0;
    end
    else
    begin
      linkHotReset    <= bctl[bcf_pkg::BIT_HOT_RST]
                      && !portIsUpstream;
      allDownHotReset <= bctl[bcf_pkg::BIT_HOT_RST]
                      && portIsUpstream;
      hotRstPrev      <= bctl[bcf_pkg::BIT_HOT_RST];
    end
  end

  // Interrupt events
  assign evSet[bcf_pkg::EV_POISON] = next_dec.poisonRpt;
  assign evSet[bcf_pkg::EV_ERRFWD] = next_dec.errFwd;
  assign evSet[bcf_pkg::EV_HOTRST] = bctl[bcf_pkg::BIT_HOT_RST]
                                  && !hotRstPrev;

  // Sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge clk_sys or negedge rstSync2)
  begin
    if (!rstSync2)
      istat <= bcf_pkg::EV_RESET;
    else if (wrDone && hitOff(paddr, bcf_pkg::OFF_ISTAT))
      istat <= (istat & ~pwdata[bcf_pkg::EV_W-1:0]) | evSet;
    else
      istat <= istat | evSet;
  end

  // Interrupt mask
  always_ff @(posedge clk_sys or negedge rstSync2)
  begin
    if (!rstSync2)
      imask <= bcf_pkg::EV_RESET;
    else if (wrDone && hitOff(paddr, bcf_pkg::OFF_IMASK))
      imask <= pwdata[bcf_pkg::EV_W-1:0];
  end

  // Level interrupt, registered so it lags status by one cycle
  always_ff @(posedge clk_sys or negedge rstSync2)
  begin
    if (!rstSync2)
      irq <= 1'b0;
    else
      irq <= |(istat & imask);
  end

  // Checks

  sequence seqBctlWrite;
    psel && penable && pready && pwrite && !pslverr
      && hitOff(paddr, bcf_pkg::OFF_BCTL);
  endsequence

  sequence seqIoReq;
    req.valid && req.isIo && inIoWin && !vgaIo;
  endsequence

  AST_POISON_GATE: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    req.valid && req.poisoned |=>
      dec.poisonRpt == $past(bctl[bcf_pkg::BIT_POISON_EN]))
    else $error("poison report does not follow its enable");

  AST_ERR_FWD: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    req.valid && req.isErrMsg |=>
      dec.errFwd == $past(bctl[bcf_pkg::BIT_ERR_FWD]))
    else $error("error forwarding does not follow its enable");

  AST_IO_DOWN: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    seqIoReq ##0 !bctl[bcf_pkg::BIT_ALIAS_EN] |=>
      dec.fwdDown && !dec.fwdUp)
    else $error("window I/O not sent downstream");

  AST_IO_ALIAS_UP: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    seqIoReq ##0 (bctl[bcf_pkg::BIT_ALIAS_EN] && aliasHit) |=>
      dec.fwdUp && !dec.fwdDown)
    else $error("alias I/O not sent upstream");

  AST_VGA_MEM: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    req.valid && req.isMem && !req.isIo
      && req.addr == bcf_pkg::VGA_MEM_HI |=>
      dec.vgaHit == $past(bctl[bcf_pkg::BIT_VGA_EN]))
    else $error("VGA memory top address mishandled");

  AST_VGA_IO16: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    req.valid && req.isIo && bctl[bcf_pkg::BIT_VGA_EN]
      && bctl[bcf_pkg::BIT_VGA16] && req.addr[15:10] != 6'h00 |=>
      !dec.vgaHit)
    else $error("16-bit VGA decode matched an alias");

  AST_VGA_IO10: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    req.valid && req.isIo && bctl[bcf_pkg::BIT_VGA_EN]
      && !bctl[bcf_pkg::BIT_VGA16] && req.addr[31:16] == 16'h0000
      && req.addr[9:0] == bcf_pkg::VGA_IO_BHI |=> dec.vgaHit)
    else $error("10-bit VGA decode missed 3DFh");

  AST_HOT_RST: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    seqBctlWrite ##0 pwdata[bcf_pkg::BIT_HOT_RST] && !portIsUpstream
      ##1 !portIsUpstream |=> linkHotReset && !allDownHotReset)
    else $error("downstream hot reset not issued");

  AST_HOT_RST_ALL: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    seqBctlWrite ##0 pwdata[bcf_pkg::BIT_HOT_RST] && portIsUpstream
      ##1 portIsUpstream |=> allDownHotReset && !linkHotReset)
    else $error("upstream hot reset not broadcast");

  AST_HOT_HOLD: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    (linkHotReset || allDownHotReset) && bctl[bcf_pkg::BIT_HOT_RST]
      && $stable(portIsUpstream) |=>
      $stable(linkHotReset) && $stable(allDownHotReset))
    else $error("hot reset dropped while bit set");

  AST_FIXED_ZERO: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    seqBctlWrite |=> bctl[31:23] == 9'h000 && !bctl[21]
      && bctl[15:0] == 16'h0000)
    else $error("fixed-zero bridge control bit changed");

  AST_EXT_WRITE: assert property (
    @(posedge clk_sys) disable iff (!rstSync2)
    psel && penable && pready && pwrite && !pslverr
      && hitOff(paddr, bcf_pkg::OFF_IO_UPPER) |=>
      ioBaseUp == $past(pwdata[15:0])
      && ioLimitUp == $past(pwdata[31:16]))
    else $error("I/O extension write lost");

endmodule

// ### sim/bcf_traffic_model.sv
// Downstream traffic source feeding the routing decoder
`timescale 1ns/1ps
module bcf_traffic_model
(
  input  wire logic         clk_sys, // Core clock
  output bcf_pkg::bcf_req_t req      // Transaction toward the decoder
);
  // One transaction after an optional idle gap, valid for one edge
  task automatic issue(input bcf_pkg::bcf_req_t r, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    req <= r;
    @(posedge clk_sys);
    req.valid <= 1'b0;
    // Released lines wander so a stale address is never reused
    req.addr <= ~r.addr;
  endtask

  // Idle until the bench asks for traffic
  initial req = '0;
endmodule

// ### sim/bcf_bridge_control_bench.sv
// Self-checking bench for the bridge control field block
`timescale 1ns/1ps
module bcf_bridge_control_bench;
  localparam logic [4:0] NONE = 5'h00;
  localparam logic [4:0] DN   = 5'h10;
  localparam logic [4:0] UP   = 5'h08;
  localparam logic [4:0] VGA  = 5'h14;
  localparam logic [4:0] ERR  = 5'h02;
  localparam logic [4:0] PZ   = 5'h01;
  logic              clk_sys        = 1'b0;
  logic              rst_b          = 1'b0;
  logic              portIsUpstream = 1'b0;
  logic              psel           = 1'b0;
  logic              penable        = 1'b0;
  logic              pwrite         = 1'b0;
  logic [11:0]       paddr          = 12'h000;
  logic [31:0]       pwdata         = 32'h0;
  bcf_pkg::bcf_req_t req;
  bcf_pkg::bcf_dec_t dec;
  logic              pready;
  logic              pslverr;
  logic [31:0]       prdata;
  logic              linkHotReset;
  logic              allDownHotReset;
  logic              irq;
  int                failCount      = 0;
  int                totalChecks    = 0;

  bcf_traffic_model bcf_traffic_model_i (.clk_sys(clk_sys), .req(req));
  bcf_bridge_control bcf_bridge_control_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .portIsUpstream(portIsUpstream), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .req(req), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .dec(dec), .linkHotReset(linkHotReset),
    .allDownHotReset(allDownHotReset), .irq(irq));

  // 100 MHz core clock
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      failCount++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Strap changes only while reset is held, keeping it static in use
  task automatic doReset(input logic up);
    rst_b <= 1'b0;
    portIsUpstream <= up;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // APB transfer; waits for pready, bounded so a hang still ends
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rdat,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic eErr);
    logic [31:0] rdat;
    logic        err;
    apb(1'b1, a, d, rdat, err);
    chk("write error", {31'h0, eErr}, {31'h0, err});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic eErr);
    logic [31:0] d;
    logic        err;
    apb(1'b0, a, 32'h0, d, err);
    chk($sformatf("read %h", a), e, d);
    chk("read error", {31'h0, eErr}, {31'h0, err});
  endtask

  // Route one transaction; expected bits are down,up,vga,err,poison
  task automatic route(input logic [3:0] k, input logic [31:0] a,
                       input logic [4:0] e);
    bcf_pkg::bcf_req_t r;
    r = {1'b1, k, a};
    bcf_traffic_model_i.issue(r, 0);
    @(posedge clk_sys);
    chk($sformatf("dec %h", a), {26'h0, 1'b1, e}, 32'(dec));
  endtask

  task automatic testRegs;
    rd(12'h03c, 32'h0, 1'b0);
    rd(12'h030, 32'h0, 1'b0);
    rd(12'h080, 32'h0, 1'b0);
    rd(12'h084, 32'h0, 1'b0);
    rd(12'h088, 32'h0, 1'b0);
    wr(12'h03c, 32'hffffffff, 1'b0);
    rd(12'h03c, 32'h005f0000, 1'b0);
    wr(12'h03c, 32'h0, 1'b0);
    // Setting bit 22 above raised the hot reset event; clear it
    rd(12'h084, 32'h4, 1'b0);
    wr(12'h084, 32'h4, 1'b0);
    rd(12'h084, 32'h0, 1'b0);
    wr(12'h03e, 32'hffffffff, 1'b1);
    rd(12'h040, 32'h0, 1'b1);
    rd(12'h03c, 32'h0, 1'b0);
    $display("test registers done");
  endtask

  // Poison and error-message gating, with the interrupt path
  task automatic testGate;
    wr(12'h088, 32'h3, 1'b0);
    rd(12'h088, 32'h3, 1'b0);
    route(4'h1, 32'h0, NONE);
    route(4'h2, 32'h0, NONE);
    rd(12'h084, 32'h0, 1'b0);
    wr(12'h03c, 32'h00030000, 1'b0);
    route(4'h1, 32'h0, PZ);
    route(4'h2, 32'h0, ERR);
    rd(12'h084, 32'h3, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h084, 32'h1, 1'b0);
    rd(12'h084, 32'h2, 1'b0);
    wr(12'h084, 32'h2, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    wr(12'h03c, 32'h0, 1'b0);
    $display("test gating done");
  endtask

  task automatic testVga;
    route(4'h4, 32'h000a0000, NONE);
    wr(12'h03c, 32'h00080000, 1'b0);
    route(4'h4, 32'h000a0000, VGA);
    route(4'h4, 32'h000bffff, VGA);
    route(4'h4, 32'h0009ffff, NONE);
    route(4'h4, 32'h000c0000, NONE);
    route(4'h8, 32'h000013b0, VGA);
    route(4'h8, 32'h000003bb, VGA);
    route(4'h8, 32'h000003bc, NONE);
    route(4'h8, 32'h000003df, VGA);
    route(4'h8, 32'h000103df, NONE);
    wr(12'h03c, 32'h00180000, 1'b0);
    route(4'h8, 32'h000013b0, NONE);
    route(4'h8, 32'h000003c0, VGA);
    wr(12'h03c, 32'h0, 1'b0);
    $display("test vga done");
  endtask

  // Window 0x00001000..0x00011fff using the upper extension fields
  task automatic testWin;
    wr(12'h030, 32'h00010000, 1'b0);
    wr(12'h080, 32'h1fff1000, 1'b0);
    route(4'h8, 32'h00001100, DN);
    route(4'h8, 32'h00000fff, NONE);
    route(4'h8, 32'h00011f00, DN);
    route(4'h8, 32'h00012000, NONE);
    wr(12'h03c, 32'h00040000, 1'b0);
    route(4'h8, 32'h00001100, UP);
    route(4'h8, 32'h00001000, DN);
    route(4'h8, 32'h0000feff, UP);
    route(4'h8, 32'h00011f00, DN);
    // VGA match inside the window wins over the alias steering
    wr(12'h03c, 32'h000c0000, 1'b0);
    route(4'h8, 32'h000013b0, VGA);
    wr(12'h03c, 32'h0, 1'b0);
    $display("test window done");
  endtask

  task automatic testHot(input logic up);
    doReset(up);
    wr(12'h03c, 32'h00400000, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("link reset", {31'h0, !up}, {31'h0, linkHotReset});
    chk("all reset", {31'h0, up}, {31'h0, allDownHotReset});
    repeat (20) @(posedge clk_sys);
    chk("held", 32'h1, {31'h0, linkHotReset | allDownHotReset});
    chk("masked irq", 32'h0, {31'h0, irq});
    rd(12'h084, 32'h4, 1'b0);
    wr(12'h088, 32'h4, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h084, 32'h4, 1'b0);
    wr(12'h03c, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("released", 32'h0, {31'h0, linkHotReset | allDownHotReset});
    chk("irq", 32'h0, {31'h0, irq});
    $display("test hot reset done");
  endtask

  initial
  begin
    doReset(1'b0);
    testRegs();
    testGate();
    testVga();
    testWin();
    testHot(1'b0);
    testHot(1'b1);
    results();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    $display("wrong value watchdog expected done seen hang");
    results();
  end
endmodule
